/* File: rtl/mpp_pkg.sv */
// Constants and types for the measurement post-processing block
package mpp_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 25000000;
    localparam int MIN_DELAY_MS = 5;
    localparam int AUTOCAL_DELAY_MS = 10;
    localparam int CAL_RECOVER_MS = 5;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int MIN_DELAY_CYC = MIN_DELAY_MS * CYC_PER_MS;
    localparam int AUTOCAL_DELAY_CYC = AUTOCAL_DELAY_MS * CYC_PER_MS;
    localparam int CAL_RECOVER_CYC = CAL_RECOVER_MS * CYC_PER_MS;
    localparam int FREE_RUN_MS = 20;
    localparam int FREE_RUN_CYC = FREE_RUN_MS * CYC_PER_MS;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_AVG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_OHM_OUT = 8'h10;
    localparam logic [7:0] ADDR_VOLT_OUT = 8'h14;
    localparam logic [7:0] ADDR_OHM_BAND = 8'h18;
    localparam logic [7:0] ADDR_VOLT_BAND = 8'h1C;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int CTRL_TRIG_EXT = 0;
    localparam int CTRL_CONTINUE = 1;
    localparam int CTRL_AUTOCAL = 2;
    localparam int CTRL_MIR_EN = 3;
    localparam int CTRL_MIR_SECONDARY = 4;
    localparam int CTRL_ZERO_FORCE = 5;
    localparam int CTRL_SIGN_STRIP = 6;
    localparam int CTRL_SPEED_LSB = 8;
    localparam int CTRL_LINE_LSB = 12;
    localparam int CTRL_ARM = 16;

    // ****************************************************************
    // Reset values and averaging limit
    // ****************************************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_0406;
    localparam logic [31:0] DELAY_RESET = 32'h0003_D090;
    localparam logic [8:0] AVG_RESET = 9'h001;
    localparam logic [8:0] AVG_MAX = 9'h100;
    localparam logic [31:0] OHM_BAND_RESET = 32'h0000_000A;
    localparam logic [31:0] VOLT_BAND_RESET = 32'h0000_0014;

    // ****************************************************************
    // Settings and states
    // ****************************************************************
    typedef enum logic [2:0] {
        MPP_SPEED_FAST_A = 3'd0,
        MPP_SPEED_FAST_B = 3'd1,
        MPP_SPEED_MED_A = 3'd2,
        MPP_SPEED_MED_B = 3'd3,
        MPP_SPEED_SLOW_A = 3'd4,
        MPP_SPEED_SLOW_B = 3'd5
    } mpp_speed_t;

    typedef enum logic [1:0] {
        MPP_LINE_AUTO = 2'd0,
        MPP_LINE_50HZ = 2'd1,
        MPP_LINE_60HZ = 2'd2
    } mpp_line_t;

    typedef enum logic [1:0] {
        MPP_ST_IDLE = 2'b00,
        MPP_ST_DELAY = 2'b01,
        MPP_ST_SAMPLE = 2'b11
    } mpp_state_t;
endpackage

/* File: rtl/mpp_top.sv */
// Trigger delay, averaging, zero band and sign strip for one channel
// Operation
// - Wait programmed delay after trigger, then sample
// - Hold off 5 ms after voltage autocal
// - Internal, single shot, autocal: 10 ms floor
// - Averaging count 1 to 256
// - Average resistance and voltage readings
// - Internal: moving if continuing, else block
// - External trigger always uses moving average
// - Clear averager on overrange or range change
// - Clear averager when error clears
// - Combined mode waits for both channels normal
// - Internal continuing outputs early; single waits
// - External withholds output until count reached
// - Secondary role reverses current mid-measurement
// - Paired instruments share speed, cal, line settings
// - Six speed choices, slow A default
// - Line auto/50/60, autocal auto/manual
// - Force readings inside zero band to zero
// - Zero band programmable per reading kind (resistance, voltage)
// - Strip sign from negative voltage readings
// - Continuation on after local or reset; free run
`timescale 1ns/1ps
`default_nettype none
module mpp_top (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hsel,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_ext_trigger,
    input wire logic i_local_mode,
    input wire logic i_cal_done,
    input wire logic i_range_change,
    input wire logic i_overrange,
    input wire logic i_ohm_error,
    input wire logic i_volt_error,
    input wire logic i_combined_mode,
    input wire logic i_reading_valid,
    input wire logic i_reading_is_volt,
    input wire logic signed [31:0] i_reading,
    input wire logic i_meas_half,
    output logic o_sample_start,
    output logic o_current_reverse,
    output logic o_result_valid,
    output logic o_result_is_volt,
    output logic signed [31:0] o_result
);
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic [31:0] ctrl_reg;
    logic [31:0] delay_reg;
    logic [8:0] avg_reg;
    logic [31:0] ohm_band_reg;
    logic [31:0] volt_band_reg;
    logic [31:0] ohm_out_reg;
    logic [31:0] volt_out_reg;
    logic [7:0] wr_addr_reg;
    logic wr_pend_reg;
    logic [7:0] rd_addr_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic local_s1_reg;
    logic local_s2_reg;
    logic local_s3_reg;
    logic cfg_change;
    logic arm_pulse;
    wire phase_ok = i_hsel && i_hready && i_htrans[1];

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= phase_ok && i_hwrite;
            if (phase_ok) begin
                wr_addr_reg <= i_haddr[7:0];
                rd_addr_reg <= i_haddr[7:0];
            end
        end
    end

    // Illegal speed codes fall back to slow A (4), illegal line code 3 to auto (0)
    function automatic logic [31:0] ctrl_legal(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[mpp_pkg::CTRL_SPEED_LSB +: 3] > 3'd5) begin
            r[mpp_pkg::CTRL_SPEED_LSB +: 3] = 3'd4;
        end
        if (v[mpp_pkg::CTRL_LINE_LSB +: 2] == 2'd3) begin
            r[mpp_pkg::CTRL_LINE_LSB +: 2] = 2'd0;
        end
        r[mpp_pkg::CTRL_ARM] = 1'b0;
        return r;
    endfunction

    wire wr_ctrl = wr_pend_reg && (wr_addr_reg == mpp_pkg::ADDR_CTRL);
    wire local_rise = local_s2_reg && !local_s3_reg;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_reg <= mpp_pkg::CTRL_RESET;
            delay_reg <= mpp_pkg::DELAY_RESET;
            avg_reg <= mpp_pkg::AVG_RESET;
            ohm_band_reg <= mpp_pkg::OHM_BAND_RESET;
            volt_band_reg <= mpp_pkg::VOLT_BAND_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_legal(i_hwdata);
            end
            if (local_rise) begin
                ctrl_reg[mpp_pkg::CTRL_CONTINUE] <= 1'b1;
            end
            if (wr_pend_reg && wr_addr_reg == mpp_pkg::ADDR_DELAY) begin
                delay_reg <= i_hwdata;
            end else if (wr_pend_reg && wr_addr_reg == mpp_pkg::ADDR_AVG) begin
                if (i_hwdata[8:0] == 9'h000) begin
                    avg_reg <= mpp_pkg::AVG_RESET;
                end else if (i_hwdata[15:0] > 16'h0100) begin
                    avg_reg <= mpp_pkg::AVG_MAX;
                end else begin
                    avg_reg <= i_hwdata[8:0];
                end
            end else if (wr_pend_reg && wr_addr_reg == mpp_pkg::ADDR_OHM_BAND) begin
                ohm_band_reg <= i_hwdata;
            end else if (wr_pend_reg && wr_addr_reg == mpp_pkg::ADDR_VOLT_BAND) begin
                volt_band_reg <= i_hwdata;
            end
        end
    end

    assign arm_pulse = wr_ctrl && i_hwdata[mpp_pkg::CTRL_ARM];
    assign cfg_change = wr_pend_reg && (wr_addr_reg == mpp_pkg::ADDR_AVG || wr_ctrl);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            local_s1_reg <= 1'b0;
            local_s2_reg <= 1'b0;
            local_s3_reg <= 1'b0;
        end else begin
            ext_s1_reg <= i_ext_trigger;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            local_s1_reg <= i_local_mode;
            local_s2_reg <= local_s1_reg;
            local_s3_reg <= local_s2_reg;
        end
    end

    // ****************************************************************
    // Trigger and delay sequencer
    // ****************************************************************
    wire trig_ext = ctrl_reg[mpp_pkg::CTRL_TRIG_EXT];
    wire cont_on = ctrl_reg[mpp_pkg::CTRL_CONTINUE];
    wire autocal = ctrl_reg[mpp_pkg::CTRL_AUTOCAL];
    mpp_pkg::mpp_state_t state_reg;
    logic [31:0] delay_cnt_reg;
    logic [31:0] cal_cnt_reg;
    logic [31:0] free_cnt_reg;
    logic armed_reg;
    logic trigger;
    logic [31:0] load_value;

    // Free-run pacing keeps the internal source from re-triggering mid-sample
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            free_cnt_reg <= 32'h0000_0000;
        end else if (free_cnt_reg == 32'h0000_0000) begin
            free_cnt_reg <= 32'(mpp_pkg::FREE_RUN_CYC - 1);
        end else begin
            free_cnt_reg <= free_cnt_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            armed_reg <= 1'b0;
        end else if (arm_pulse) begin
            armed_reg <= 1'b1;
        end else if (trigger) begin
            armed_reg <= 1'b0;
        end
    end

    always_comb begin
        trigger = 1'b0;
        if (trig_ext) begin
            trigger = ext_s2_reg && !ext_s3_reg && (cont_on || armed_reg);
        end else if (cont_on) begin
            trigger = (free_cnt_reg == 32'h0000_0000);
        end else begin
            trigger = armed_reg;
        end
    end

    // Program floor applied in hardware; a short setting cannot corrupt sampling
    always_comb begin
        load_value = delay_reg;
        if (load_value < 32'(mpp_pkg::MIN_DELAY_CYC)) begin
            load_value = 32'(mpp_pkg::MIN_DELAY_CYC);
        end
        if (!trig_ext && !cont_on && autocal &&
            load_value < 32'(mpp_pkg::AUTOCAL_DELAY_CYC)) begin
            load_value = 32'(mpp_pkg::AUTOCAL_DELAY_CYC);
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cal_cnt_reg <= 32'h0000_0000;
        end else if (i_cal_done) begin
            cal_cnt_reg <= 32'(mpp_pkg::CAL_RECOVER_CYC);
        end else if (cal_cnt_reg != 32'h0000_0000) begin
            cal_cnt_reg <= cal_cnt_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= mpp_pkg::MPP_ST_IDLE;
            delay_cnt_reg <= 32'h0000_0000;
            o_sample_start <= 1'b0;
        end else begin
            o_sample_start <= 1'b0;
            if (trigger) begin
                state_reg <= mpp_pkg::MPP_ST_DELAY;
                delay_cnt_reg <= load_value - 32'h0000_0001;
            end else begin
                case (state_reg)
                    mpp_pkg::MPP_ST_DELAY: begin
                        if (delay_cnt_reg != 32'h0000_0000) begin
                            delay_cnt_reg <= delay_cnt_reg - 32'h0000_0001;
                        end else if (cal_cnt_reg == 32'h0000_0000) begin
                            state_reg <= mpp_pkg::MPP_ST_SAMPLE;
                            o_sample_start <= 1'b1;
                        end
                    end
                    mpp_pkg::MPP_ST_SAMPLE: begin
                        state_reg <= mpp_pkg::MPP_ST_IDLE;
                    end
                    default: begin
                        state_reg <= mpp_pkg::MPP_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Phase reversal for interference reduction
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_current_reverse <= 1'b0;
        end else begin
            o_current_reverse <= ctrl_reg[mpp_pkg::CTRL_MIR_EN] &&
                ctrl_reg[mpp_pkg::CTRL_MIR_SECONDARY] && i_meas_half;
        end
    end

    // ****************************************************************
    // Averager
    // ****************************************************************
    logic [31:0] hist_reg [0:255];
    logic [7:0] wptr_reg;
    logic [8:0] fill_reg;
    logic signed [39:0] sum_reg;
    logic err_seen_reg;
    logic avg_clear;
    logic moving;
    logic [7:0] oldest;
    wire err_now = i_combined_mode ? (i_ohm_error || i_volt_error) :
        (i_reading_is_volt ? i_volt_error : i_ohm_error);
    // Only one stream is averaged at a time; a kind switch restarts the sum
    logic kind_reg;

    assign moving = trig_ext || cont_on;
    assign avg_clear = i_overrange || i_range_change || cfg_change ||
        (err_seen_reg && !(i_ohm_error || i_volt_error)) ||
        (i_reading_valid && i_reading_is_volt != kind_reg);
    assign oldest = wptr_reg - avg_reg[7:0];

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            err_seen_reg <= 1'b0;
            kind_reg <= 1'b0;
        end else begin
            if (err_now) begin
                err_seen_reg <= 1'b1;
            end else if (!(i_ohm_error || i_volt_error)) begin
                err_seen_reg <= 1'b0;
            end
            if (i_reading_valid) begin
                kind_reg <= i_reading_is_volt;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reading_valid && !err_now) begin
            hist_reg[avg_clear ? 8'h00 : wptr_reg] <= i_reading;
        end
    end

    function automatic logic signed [39:0] sext(input logic [31:0] v);
        return {{8{v[31]}}, v};
    endfunction

    logic signed [39:0] sum_next;
    logic [8:0] fill_next;
    always_comb begin
        sum_next = sum_reg + sext(i_reading);
        fill_next = fill_reg + 9'h001;
        if (avg_clear) begin
            sum_next = sext(i_reading);
            fill_next = 9'h001;
        end else if (fill_reg == avg_reg) begin
            if (moving) begin
                sum_next = sum_reg + sext(i_reading) - sext(hist_reg[oldest]);
                fill_next = fill_reg;
            end else begin
                sum_next = sext(i_reading);
                fill_next = 9'h001;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sum_reg <= 40'sh00_0000_0000;
            fill_reg <= 9'h000;
            wptr_reg <= 8'h00;
        end else if (i_reading_valid && !err_now) begin
            sum_reg <= sum_next;
            fill_reg <= fill_next;
            wptr_reg <= avg_clear ? 8'h01 : wptr_reg + 8'h01;
        end else if (avg_clear) begin
            sum_reg <= 40'sh00_0000_0000;
            fill_reg <= 9'h000;
            wptr_reg <= 8'h00;
        end
    end

    // ****************************************************************
    // Output shaping
    // ****************************************************************
    logic signed [39:0] mean;
    logic signed [31:0] shaped;
    logic emit;
    always_comb begin
        mean = sum_next / $signed({31'h0000_0000, fill_next});
        shaped = mean[31:0];
        if (i_reading_is_volt && ctrl_reg[mpp_pkg::CTRL_SIGN_STRIP] && shaped < 0) begin
            shaped = -shaped;
        end
        if (ctrl_reg[mpp_pkg::CTRL_ZERO_FORCE]) begin
            if ((shaped < 0 ? -shaped : shaped) <=
                $signed(i_reading_is_volt ? volt_band_reg : ohm_band_reg)) begin
                shaped = 32'sh0000_0000;
            end
        end
        emit = (!trig_ext && cont_on) || (fill_next == avg_reg);
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_result_valid <= 1'b0;
            o_result_is_volt <= 1'b0;
            o_result <= 32'sh0000_0000;
            ohm_out_reg <= 32'h0000_0000;
            volt_out_reg <= 32'h0000_0000;
        end else begin
            o_result_valid <= i_reading_valid && !err_now && emit;
            if (i_reading_valid && !err_now && emit) begin
                o_result <= shaped;
                o_result_is_volt <= i_reading_is_volt;
                if (i_reading_is_volt) begin
                    volt_out_reg <= shaped;
                end else begin
                    ohm_out_reg <= shaped;
                end
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        if (rd_addr_reg == mpp_pkg::ADDR_CTRL) begin
            o_hrdata = ctrl_reg;
        end else if (rd_addr_reg == mpp_pkg::ADDR_DELAY) begin
            o_hrdata = delay_reg;
        end else if (rd_addr_reg == mpp_pkg::ADDR_AVG) begin
            o_hrdata = {23'h00_0000, avg_reg};
        end else if (rd_addr_reg == mpp_pkg::ADDR_STATUS) begin
            o_hrdata = {12'h000, 1'b0, fill_reg, 5'h00, armed_reg, state_reg, 2'b00};
        end else if (rd_addr_reg == mpp_pkg::ADDR_OHM_OUT) begin
            o_hrdata = ohm_out_reg;
        end else if (rd_addr_reg == mpp_pkg::ADDR_VOLT_OUT) begin
            o_hrdata = volt_out_reg;
        end else if (rd_addr_reg == mpp_pkg::ADDR_OHM_BAND) begin
            o_hrdata = ohm_band_reg;
        end else if (rd_addr_reg == mpp_pkg::ADDR_VOLT_BAND) begin
            o_hrdata = volt_band_reg;
        end else begin
            o_hrdata = 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* File: verif/mpp_monitor.sv */
// Checker for trigger timing, result pulses and bus response
`timescale 1ns/1ps
`default_nettype none
module mpp_monitor (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_reading_valid,
    input wire logic i_reading_is_volt,
    input wire logic i_meas_half,
    input wire logic i_cal_done,
    input wire logic o_sample_start,
    input wire logic o_current_reverse,
    input wire logic o_result_valid,
    input wire logic o_result_is_volt,
    input wire logic o_hreadyout,
    input wire logic o_hresp
);
    // ****************
    // Counters and properties
    // ****************
    // Two cycles of slack cover the synchroniser and the output flop
    localparam int GAP_MIN = mpp_pkg::MIN_DELAY_CYC - 2;
    localparam int CAL_MIN = mpp_pkg::CAL_RECOVER_CYC - 2;
    int gap_reg;
    int cal_reg;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) gap_reg <= 0;
        else if (o_sample_start) gap_reg <= 0;
        else if (gap_reg < GAP_MIN) gap_reg <= gap_reg + 1;
    end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) cal_reg <= CAL_MIN;
        else if (i_cal_done) cal_reg <= 0;
        else if (cal_reg < CAL_MIN) cal_reg <= cal_reg + 1;
    end
    chk_start_pulse: assert property (o_sample_start |=> !o_sample_start)
        else $error("sample start longer than one cycle");
    chk_start_gap: assert property (o_sample_start |-> gap_reg >= GAP_MIN)
        else $error("sample start before delay floor");
    chk_cal_hold: assert property (o_sample_start |-> cal_reg >= CAL_MIN)
        else $error("sample start inside cal hold-off");
    chk_result_cause: assert property (o_result_valid |-> $past(i_reading_valid))
        else $error("result without a reading");
    chk_result_kind: assert property (o_result_valid |->
        o_result_is_volt == $past(i_reading_is_volt))
        else $error("result kind differs from reading");
    chk_reverse_half: assert property (o_current_reverse |-> $past(i_meas_half))
        else $error("current reversed in first half");
    chk_bus_ready: assert property (o_hreadyout)
        else $error("bus ready dropped");
    chk_bus_okay: assert property (!o_hresp)
        else $error("bus response not okay");
    cov_result: cover property (o_result_valid);
    cov_start: cover property (o_sample_start);
    cov_reverse: cover property (o_current_reverse);
endmodule
bind mpp_top mpp_monitor mpp_monitor_i (.i_clock, .i_resetn, .i_reading_valid,
    .i_reading_is_volt, .i_meas_half, .i_cal_done, .o_sample_start, .o_current_reverse,
    .o_result_valid, .o_result_is_volt, .o_hreadyout, .o_hresp);
`default_nettype wire

/* File: verif/mpp_partner.sv */
// Trigger source and paired-instrument model
`timescale 1ns/1ps
`default_nettype none
module mpp_partner (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_fire,
    output logic o_ext_trigger,
    output logic o_meas_half
);
    // ****************
    // Paired instrument and trigger
    // ****************
    logic [3:0] phase_reg;
    logic [2:0] hold_reg;
    // Halves only; contacts never change mid-measurement
    // Speed, cal and line taken as equal to ours
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) phase_reg <= 4'h0;
        else phase_reg <= phase_reg + 4'h1;
    end
    assign o_meas_half = phase_reg[3];
    // Held four cycles past fire so the synchroniser cannot miss it
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) hold_reg <= 3'h0;
        else if (i_fire) hold_reg <= 3'h4;
        else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
    assign o_ext_trigger = hold_reg != 3'h0;
endmodule
`default_nettype wire

/* File: verif/tb_measurement_postprocess.sv */
// Self-checking bench for the measurement post-processing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_measurement_postprocess;
    // ****************
    // Bench, model and scenarios
    // ****************
    logic i_clock, i_resetn, i_hwrite, i_hsel, hready, ext_trig, meas_half, fire;
    logic i_local_mode, i_cal_done, i_range_change, i_overrange, i_ohm_error;
    logic i_volt_error, i_combined_mode, i_reading_valid, i_reading_is_volt;
    logic o_result_valid, o_result_is_volt;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic signed [31:0] i_reading, o_result;
    int err_total, tests_run, n, band;
    int q[$];
    bit moving, early, zf, ss;
    int ctl[6] = '{32'h0000_0D07, 32'h0000_0D06, 32'h0000_0D04, 32'h0000_0D66,
        32'h0000_0D26, 32'h0000_0D46};
    int nn[6] = '{4, 3, 4, 1, 1, 1};
    int ev[6] = '{1, 3, 2, 0, 0, 0};
    bit kd[6] = '{0, 1, 0, 1, 0, 0};
    logic [7:0] ra[6] = '{mpp_pkg::ADDR_CTRL, mpp_pkg::ADDR_DELAY, mpp_pkg::ADDR_AVG,
        mpp_pkg::ADDR_OHM_BAND, mpp_pkg::ADDR_VOLT_BAND, 8'h40};
    logic [31:0] rv[6] = '{32'h0000_0406, mpp_pkg::DELAY_RESET, 32'(mpp_pkg::AVG_RESET),
        mpp_pkg::OHM_BAND_RESET, mpp_pkg::VOLT_BAND_RESET, 32'h0000_0000};
    mpp_top mpp_top_i (.i_clock, .i_resetn, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
        .i_hwdata, .i_hsel, .i_hready(hready), .o_hrdata, .o_hreadyout(hready), .o_hresp(),
        .i_ext_trigger(ext_trig), .i_local_mode, .i_cal_done, .i_range_change, .i_overrange,
        .i_ohm_error, .i_volt_error, .i_combined_mode, .i_reading_valid, .i_reading_is_volt,
        .i_reading, .i_meas_half(meas_half), .o_sample_start(), .o_current_reverse(),
        .o_result_valid, .o_result_is_volt, .o_result);
    mpp_partner mpp_partner_i (.i_clock, .i_resetn, .i_fire(fire),
        .o_ext_trigger(ext_trig), .o_meas_half(meas_half));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (hready !== 1'b1 && k < 64);
        if (k >= 64) begin
            `CHK("bus ready", 1'b1, hready)
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_haddr <= {24'h00_0000, a};
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_hsel <= 1'b1;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wait_rdy();
        rd = o_hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK("register", e, rd)
    endtask
    // Overrange, range change, voltage error, resistance error
    task automatic clr(input int c);
        {i_overrange, i_range_change, i_volt_error, i_ohm_error} <= 4'(8 >> (c - 1));
        repeat (2) @(posedge i_clock);
        {i_overrange, i_range_change, i_volt_error, i_ohm_error} <= 4'h0;
        repeat (3) @(posedge i_clock);
        q.delete();
    endtask
    task automatic feed(input logic v, input int x);
        int s;
        bit full;
        i_reading_valid <= 1'b1;
        i_reading_is_volt <= v;
        i_reading <= x;
        @(posedge i_clock);
        i_reading_valid <= 1'b0;
        @(posedge i_clock);
        q.push_back(x);
        if (q.size() > n) void'(q.pop_front());
        full = q.size() == n;
        s = 0;
        foreach (q[i]) s += q[i];
        s = s / n;
        if (ss && v && s < 0) s = -s;
        `CHK("result valid", full || early, o_result_valid)
        if (full) begin
            if (zf && s <= band && s >= -band) s = 0;
            `CHK("result", 32'(s), o_result)
            `CHK("result kind", v, o_result_is_volt)
            rchk(v ? mpp_pkg::ADDR_VOLT_OUT : mpp_pkg::ADDR_OHM_OUT, 32'(s));
        end
        if (full && !moving) q.delete();
    endtask
    initial begin
        {i_hwrite, i_hsel, i_local_mode, i_cal_done, i_range_change, i_overrange} = '0;
        {i_ohm_error, i_volt_error, i_combined_mode, i_reading_valid} = '0;
        {i_reading_is_volt, fire, i_resetn} = '0;
        i_haddr = '0;
        i_hwdata = '0;
        i_htrans = 2'h0;
        i_hsize = 3'h2;
        i_reading = '0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(32'hcb8a6e6d));
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'b1;
        foreach (ra[i]) rchk(ra[i], rv[i]);
        $display("test reset values done");
        bus(1'b1, mpp_pkg::ADDR_AVG, 32'h0000_01FF);
        rchk(mpp_pkg::ADDR_AVG, 32'h0000_0100);
        bus(1'b1, mpp_pkg::ADDR_AVG, 32'h0000_0000);
        rchk(mpp_pkg::ADDR_AVG, 32'h0000_0001);
        // Delay stays at its 10 ms reset value, above the floor
        bus(1'b1, mpp_pkg::ADDR_CTRL, 32'h0000_3704);
        i_local_mode <= 1'b1;
        repeat (6) @(posedge i_clock);
        i_local_mode <= 1'b0;
        rchk(mpp_pkg::ADDR_CTRL, 32'h0000_0406);
        $display("test limits and local mode done");
        for (int t = 0; t < 6; t++) begin
            bus(1'b1, mpp_pkg::ADDR_CTRL, ctl[t]);
            bus(1'b1, mpp_pkg::ADDR_AVG, nn[t]);
            n = nn[t];
            moving = ctl[t][0] | ctl[t][1];
            early = !ctl[t][0] && ctl[t][1];
            zf = ctl[t][5];
            ss = ctl[t][6];
            band = kd[t] ? 20 : 10;
            q.delete();
            fire <= t == 0;
            for (int k = 0; k < 8; k++) begin
                if (k == 5 && ev[t] != 0) clr(ev[t]);
                feed(kd[t], n * (int'($urandom_range(80)) - 40) + 1);
            end
            $display("test mode %0d done", t);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
